// ---- logic/reset_seq_pkg.sv ----
// Purpose: Constants and carriers for the reset sequencer
// Assumes: One 25 MHz clock that stands for the internal oscillator clock
// Notes:   Cycle counts are in internal clock cycles
package reset_seq_pkg;

    // Cycle counts of the reset sequence, counter widths and bit positions
    localparam int unsigned POR_STAB_CYC   = 4096;
    localparam int unsigned PIN_DRIVE_CYC  = 32;
    localparam int unsigned INTERNAL_RESET_SIGNAL_TAIL_CYC  = 32;
    localparam int unsigned PIN_MIN_CYC    = 67;
    localparam int unsigned PIN_POR_CYC    = 4163;
    localparam int unsigned SHORT_REC_CYC  = 32;
    localparam int unsigned LONG_REC_CYC   = 4096;
    localparam int unsigned PRESC_BITS     = 13;
    localparam int unsigned SVC_LO_BIT     = 5;
    localparam int unsigned SVC_HI_BIT     = 12;
    localparam int unsigned WDOG_BITS      = 8;
    localparam int unsigned SEQ_BITS       = 13;

    // Reset vectors and the watchdog service address
    localparam logic [15:0] VEC_NORMAL     = 16'hFFFE;
    localparam logic [15:0] VEC_MONITOR    = 16'hFEFE;
    localparam logic [15:0] WDOG_SVC_ADDR  = 16'hFFFF;

    // Avalon register byte addresses
    localparam logic [3:0] CAUSE_ADDR      = 4'h0;
    localparam logic [3:0] PRESC_ADDR      = 4'h4;
    localparam logic [3:0] CTRL_ADDR       = 4'h8;
    localparam logic [3:0] WDOG_ADDR       = 4'hC;

    // Reset cause flag positions
    localparam int unsigned CAUSE_POR      = 7;
    localparam int unsigned CAUSE_PIN      = 6;
    localparam int unsigned CAUSE_WDOG     = 5;
    localparam int unsigned CAUSE_ILLEGAL_OPCODE_FLAG     = 4;
    localparam int unsigned CAUSE_ILLEGAL_ADDRESS_FLAG     = 3;
    localparam int unsigned CAUSE_MONITOR_ENTRY_RESET   = 2;
    localparam int unsigned CAUSE_LVI      = 1;

    // Control register field positions
    localparam int unsigned CTRL_STOP_EN   = 0;
    localparam int unsigned CTRL_SHORT_RECOVERY_OPTION     = 1;
    localparam int unsigned CTRL_WDOG_EN   = 2;
    localparam logic [7:0]  CTRL_RESET     = 8'h05;

    // Reset sequence states
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_STAB    = 3'b001,
        ST_PIN     = 3'b010,
        ST_TAIL    = 3'b011,
        ST_EXT     = 3'b100,
        ST_STOP    = 3'b101,
        ST_RECOVER = 3'b110
    } seq_state_t;

    // Reset sources from the chip
    typedef struct packed {
        logic por;
        logic low_voltage_inhibit;
        logic illegal_opcode_flag;
        logic illegal_address_flag;
        logic monitor_entry_reset;
    } src_t;

    // CPU status signals
    typedef struct packed {
        logic        illegal_op;
        logic        stop_exec;
        logic        opcode_fetch;
        logic        unmapped;
        logic        wake;
        logic        cpu_write;
        logic [15:0] cpu_addr;
    } cpu_t;

endpackage : reset_seq_pkg

// ---- logic/presc_counter.sv ----
// Purpose: Free running 13-bit prescaler with watchdog tick
// Assumes: Enable marks a falling edge of the selected oscillator clock
// Notes:   Clear wins over partial clear and count
`timescale 1ns/100ps
module presc_counter (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic                                   tick_en,
    input  wire logic                                   clear,
    input  wire logic                                   svc_clear,
    output logic [reset_seq_pkg::PRESC_BITS-1:0]        count,
    output logic                                        ovf
);
    localparam logic [reset_seq_pkg::PRESC_BITS-1:0] SVC_MASK =
        13'h001F;
    localparam logic [reset_seq_pkg::PRESC_BITS-1:0] ONE = 13'h0001;

    // Count, clear and overflow pulse
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count <= '0;
            ovf   <= 1'b0;
        end else if (svc_clear) begin
            count <= count & SVC_MASK;
            ovf   <= 1'b0;
        end else begin
            ovf <= tick_en && (&count);
            if (tick_en)
                count <= count + ONE;
        end
    end

endmodule : presc_counter

// ---- logic/reset_sequencer.sv ----
// Purpose: Reset sequencer, cause flags, prescaler and watchdog
// Assumes: Inputs synchronous to clk except the reset pin level
// Notes:   Registers over Avalon-MM, one wait state on every access
// Summary of operation
// - Any reset asserts internal reset, selects vector
// - Internal reset in run clears prescaler, pin reset not
// - Each reset sets its cause flag
// - Pin flag needs 67 or 4163 low cycles
// - Internal sources drive pin low 32 cycles, 4096+32 when they end stop
// - Internal reset holds 32 more cycles
// - Power or low voltage: pin low 4096+32
// - Power-on: clock output on, bus clocks held
// - Power-on sets its flag, clears others
// - Watchdog overflow resets and sets flag
// - Write to FFFF clears watchdog, prescaler 12:5
// - Prescaler overflow clocks the watchdog
// - Watchdog disabled by test voltage in monitor mode or break state, or by clearing CTRL_WDOG_EN
// - Illegal instruction sets flag and resets
// - Stop disabled makes stop illegal opcode
// - Unmapped opcode fetch resets, data fetch not
// - Low voltage sets flag, long pin drive
// - Monitor entry reset drives pin low
// - Prescaler 13 bits on oscillator falling edge
// - Stop instruction clears the prescaler
// - Stop recovery 32 or 4096 cycles
// - Prescaler runs freely after reset
`timescale 1ns/100ps
module reset_sequencer (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   osc_fall_en,
    input  wire logic                   rst_pin_in,
    input  wire logic                   rst_pin_test_high_voltage,
    input  wire logic                   ext_interrupt_pin_one_test_high_voltage,
    input  wire logic                   monitor_mode,
    input  wire logic                   break_state,
    input  reset_seq_pkg::src_t         src,
    input  reset_seq_pkg::cpu_t         cpu,
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic                        rst_pin_out,
    output logic                        rst_pin_oe,
    output logic                        internal_reset_signal,
    output logic                        clock_gen_output,
    output logic                        internal_bus_clocks,
    output logic [15:0]                 reset_vector
);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] STAB_N =
        13'(reset_seq_pkg::POR_STAB_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] PIN_N =
        13'(reset_seq_pkg::PIN_DRIVE_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] TAIL_N =
        13'(reset_seq_pkg::INTERNAL_RESET_SIGNAL_TAIL_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] PMIN_N =
        13'(reset_seq_pkg::PIN_MIN_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] PPOR_N =
        13'(reset_seq_pkg::PIN_POR_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] LONG_N =
        13'(reset_seq_pkg::POR_STAB_CYC + reset_seq_pkg::PIN_DRIVE_CYC);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] SREC_N =
        13'(reset_seq_pkg::SHORT_REC_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] LREC_N =
        13'(reset_seq_pkg::LONG_REC_CYC - 1);
    localparam logic [reset_seq_pkg::SEQ_BITS-1:0] SEQ_ONE = 13'h0001;
    localparam logic [reset_seq_pkg::WDOG_BITS-1:0] WD_ONE = 8'h01;

    ////////////////////////////////////////////////////////////////////
    // State
    reset_seq_pkg::seq_state_t          state;
    reset_seq_pkg::seq_state_t          next_state;
    logic [reset_seq_pkg::SEQ_BITS-1:0] seq_cnt;
    logic [reset_seq_pkg::SEQ_BITS-1:0] pin_low_cnt;
    logic [reset_seq_pkg::WDOG_BITS-1:0] wdog_cnt;
    logic [7:0]                         cause;
    logic [7:0]                         ctrl;
    logic                               long_seq;
    logic                               pin_s1;
    logic                               pin_s2;
    logic                               oe_s1;
    logic                               oe_s2;
    logic [reset_seq_pkg::SEQ_BITS-1:0] drive_cnt;
    logic                               acc_done;
    logic [12:0]                        presc;
    logic                               presc_ovf;

    ////////////////////////////////////////////////////////////////////
    // Source decode
    wire stop_illegal = cpu.stop_exec && !ctrl[reset_seq_pkg::CTRL_STOP_EN];
    wire illegal_opcode_flag_hit  = src.illegal_opcode_flag || cpu.illegal_op || stop_illegal;
    wire illegal_address_flag_hit  = src.illegal_address_flag
                   || (cpu.unmapped && cpu.opcode_fetch);
    wire wdog_off  = (monitor_mode && (rst_pin_test_high_voltage || ext_interrupt_pin_one_test_high_voltage))
                   || (break_state && rst_pin_test_high_voltage);
    wire wdog_trip = presc_ovf && (&wdog_cnt) && !wdog_off
                   && ctrl[reset_seq_pkg::CTRL_WDOG_EN];
    wire long_hit  = src.por || src.low_voltage_inhibit;
    wire int_hit   = long_hit || illegal_opcode_flag_hit || illegal_address_flag_hit || wdog_trip
                   || src.monitor_entry_reset;
    wire in_reset  = (state != reset_seq_pkg::ST_RUN)
                   && (state != reset_seq_pkg::ST_STOP)
                   && (state != reset_seq_pkg::ST_RECOVER);
    wire ext_low   = !pin_s2 && !rst_pin_oe && !oe_s1 && !oe_s2;
    wire svc_write = cpu.cpu_write
                   && (cpu.cpu_addr == reset_seq_pkg::WDOG_SVC_ADDR);
    wire sw_svc    = avs_write && acc_done
                   && (avs_address == reset_seq_pkg::WDOG_ADDR);
    wire do_svc    = svc_write || sw_svc;
    wire presc_clr = (int_hit && state == reset_seq_pkg::ST_RUN)
                   || (cpu.stop_exec && !stop_illegal)
                   || src.por;
    wire [reset_seq_pkg::SEQ_BITS-1:0] rec_n =
        ctrl[reset_seq_pkg::CTRL_SHORT_RECOVERY_OPTION] ? SREC_N : LREC_N;
    wire [reset_seq_pkg::SEQ_BITS-1:0] pin_need =
        long_seq ? PPOR_N : PMIN_N;

    ////////////////////////////////////////////////////////////////////
    // Prescaler on oscillator falling edge enable
    presc_counter u_presc (
        .clk       (clk),
        .rst       (rst),
        .tick_en   (osc_fall_en),
        .clear     (presc_clr),
        .svc_clear (do_svc),
        .count     (presc),
        .ovf       (presc_ovf)
    );

    ////////////////////////////////////////////////////////////////////
    // Reset pin synchroniser
    always_ff @(posedge clk) begin
        pin_s1 <= rst ? 1'b1 : rst_pin_in;
        pin_s2 <= rst ? 1'b1 : pin_s1;
        oe_s1  <= rst ? 1'b1 : rst_pin_oe;   // Masks own drive in flight
        oe_s2  <= rst ? 1'b1 : oe_s1;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state of the sequencer
    always_comb begin
        next_state = state;
        case (state)
            reset_seq_pkg::ST_RUN: begin
                if (long_hit)
                    next_state = reset_seq_pkg::ST_STAB;
                else if (int_hit)
                    next_state = reset_seq_pkg::ST_PIN;
                else if (ext_low)
                    next_state = reset_seq_pkg::ST_EXT;
                else if (cpu.stop_exec && !stop_illegal)
                    next_state = reset_seq_pkg::ST_STOP;
            end
            reset_seq_pkg::ST_STAB: begin
                if (seq_cnt == STAB_N)
                    next_state = reset_seq_pkg::ST_PIN;
            end
            reset_seq_pkg::ST_PIN: begin
                if (seq_cnt == PIN_N)
                    next_state = reset_seq_pkg::ST_TAIL;
            end
            reset_seq_pkg::ST_TAIL: begin
                if (seq_cnt == TAIL_N)
                    next_state = ext_low ? reset_seq_pkg::ST_EXT
                                         : reset_seq_pkg::ST_RUN;
            end
            reset_seq_pkg::ST_EXT: begin
                if (!ext_low)
                    next_state = reset_seq_pkg::ST_TAIL;
            end
            reset_seq_pkg::ST_STOP: begin
                if (long_hit || int_hit)
                    next_state = reset_seq_pkg::ST_STAB;
                else if (cpu.wake || ext_low)
                    next_state = reset_seq_pkg::ST_RECOVER;
            end
            reset_seq_pkg::ST_RECOVER: begin
                if (seq_cnt == rec_n)
                    next_state = reset_seq_pkg::ST_RUN;
            end
            default: next_state = reset_seq_pkg::ST_RUN;
        endcase
        if (state != reset_seq_pkg::ST_STOP && long_hit
            && state != reset_seq_pkg::ST_STAB)
            next_state = reset_seq_pkg::ST_STAB;
    end

    ////////////////////////////////////////////////////////////////////
    // State, sequence counter and long-sequence marker
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= reset_seq_pkg::ST_STAB;
            seq_cnt  <= '0;
            long_seq <= 1'b1;
        end else begin
            state   <= next_state;
            seq_cnt <= (next_state != state) ? '0 : seq_cnt + SEQ_ONE;
            if (long_hit)
                long_seq <= 1'b1;
            else if (state == reset_seq_pkg::ST_RUN && !ext_low)
                long_seq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Low time of the external pin
    always_ff @(posedge clk) begin
        if (rst || !ext_low)
            pin_low_cnt <= '0;
        else if (pin_low_cnt != PPOR_N)
            pin_low_cnt <= pin_low_cnt + SEQ_ONE;
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog counter clocked by prescaler overflow
    always_ff @(posedge clk) begin
        if (rst || in_reset || do_svc || wdog_off)
            wdog_cnt <= '0;
        else if (presc_ovf)
            wdog_cnt <= wdog_cnt + WD_ONE;
    end

    ////////////////////////////////////////////////////////////////////
    // Reset cause flags, set wins over software clear
    logic [7:0] cause_set;
    always_comb begin
        cause_set = '0;
        cause_set[reset_seq_pkg::CAUSE_PIN]    = (pin_low_cnt == pin_need)
                                               && ext_low;
        cause_set[reset_seq_pkg::CAUSE_WDOG]   = wdog_trip;
        cause_set[reset_seq_pkg::CAUSE_ILLEGAL_OPCODE_FLAG]   = illegal_opcode_flag_hit;
        cause_set[reset_seq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG]   = illegal_address_flag_hit;
        cause_set[reset_seq_pkg::CAUSE_MONITOR_ENTRY_RESET] = src.monitor_entry_reset;
        cause_set[reset_seq_pkg::CAUSE_LVI]    = src.low_voltage_inhibit;
    end

    wire cause_rd = avs_read && acc_done
                  && (avs_address == reset_seq_pkg::CAUSE_ADDR);

    always_ff @(posedge clk) begin
        if (rst || src.por)
            cause <= 8'h80;
        else
            cause <= (cause_rd ? 8'h00 : cause) | cause_set;
    end

    ////////////////////////////////////////////////////////////////////
    // Avalon slave, one wait state
    wire [31:0] rd_mux =
        (avs_address == reset_seq_pkg::CAUSE_ADDR) ? {24'h0, cause} :
        (avs_address == reset_seq_pkg::PRESC_ADDR) ? {19'h0, presc} :
        (avs_address == reset_seq_pkg::CTRL_ADDR)  ? {24'h0, ctrl}  :
        (avs_address == reset_seq_pkg::WDOG_ADDR)  ? {24'h0, wdog_cnt} :
        32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst || internal_reset_signal) begin
            acc_done     <= 1'b0;
            avs_readdata <= '0;
            ctrl         <= reset_seq_pkg::CTRL_RESET;
        end else begin
            acc_done <= (avs_read || avs_write) && !acc_done;
            if (avs_read && !acc_done)
                avs_readdata <= rd_mux;
            if (avs_write && acc_done
                && avs_address == reset_seq_pkg::CTRL_ADDR)
                ctrl <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest       <= 1'b1;
            rst_pin_out           <= 1'b0;
            rst_pin_oe            <= 1'b1;
            internal_reset_signal <= 1'b1;
            clock_gen_output      <= 1'b1;
            internal_bus_clocks   <= 1'b0;
            reset_vector          <= reset_seq_pkg::VEC_NORMAL;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
            rst_pin_out     <= 1'b0;
            rst_pin_oe      <= (next_state == reset_seq_pkg::ST_STAB)
                            || (next_state == reset_seq_pkg::ST_PIN);
            internal_reset_signal <= (next_state != reset_seq_pkg::ST_RUN)
                && (next_state != reset_seq_pkg::ST_STOP)
                && (next_state != reset_seq_pkg::ST_RECOVER);
            clock_gen_output      <= 1'b1;
            internal_bus_clocks   <= (next_state == reset_seq_pkg::ST_RUN);
            reset_vector <= monitor_mode ? reset_seq_pkg::VEC_MONITOR
                                         : reset_seq_pkg::VEC_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Length of the own pin drive, for the long drive check
    always_ff @(posedge clk) begin
        if (rst || !rst_pin_oe)
            drive_cnt <= '0;
        else if (!(&drive_cnt))
            drive_cnt <= drive_cnt + SEQ_ONE;
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    pin_drive_a: assert property (@(posedge clk) disable iff (rst)
        (state == reset_seq_pkg::ST_PIN && seq_cnt != PIN_N)
            |=> rst_pin_oe)
        else $error("pin drive ended early");
    tail_len_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(state == reset_seq_pkg::ST_TAIL) && !ext_low)
            |-> ##32 !internal_reset_signal)
        else $error("internal reset tail wrong length");
    por_flag_a: assert property (@(posedge clk) disable iff (rst)
        src.por |=> cause == 8'h80)
        else $error("power-on flags wrong");
    wdog_flag_a: assert property (@(posedge clk) disable iff (rst)
        (wdog_trip && !src.por) |=> cause[reset_seq_pkg::CAUSE_WDOG])
        else $error("watchdog flag missing");
    illegal_opcode_flag_rst_a: assert property (@(posedge clk) disable iff (rst)
        (illegal_opcode_flag_hit && !long_hit && state == reset_seq_pkg::ST_RUN)
            |=> state == reset_seq_pkg::ST_PIN)
        else $error("illegal opcode did not reset");
    data_fetch_a: assert property (@(posedge clk) disable iff (rst)
        (cpu.unmapped && !cpu.opcode_fetch && !src.illegal_address_flag
            && !cause[reset_seq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG])
            |=> !cause[reset_seq_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG])
        else $error("data fetch flagged");
    long_seq_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(rst_pin_oe) && long_seq) |-> drive_cnt >= LONG_N)
        else $error("long pin drive too short");
    svc_clear_a: assert property (@(posedge clk) disable iff (rst)
        (do_svc && !wdog_trip) |=> wdog_cnt == 8'h00)
        else $error("watchdog not cleared by service");
    svc_presc_a: assert property (@(posedge clk) disable iff (rst)
        (do_svc && !presc_clr)
            |=> (presc >> reset_seq_pkg::SVC_LO_BIT) == '0)
        else $error("prescaler upper bits not cleared");
    bus_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == reset_seq_pkg::ST_STAB) |-> !internal_bus_clocks)
        else $error("bus clocks during stabilisation");

endmodule : reset_sequencer

// ---- bench/reset_pin_partner.sv ----
// Purpose: Far side of the reset pin and the oscillator edge source
// Assumes: The pin has a pull-up; an outside chip may pull it low
// Notes:   Oscillator falling edge marked every second clk cycle
`timescale 1ns/100ps
module reset_pin_partner (
    input  wire logic clk,
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_out,
    input  wire logic ext_low,
    output logic      pin_level,
    output logic      osc_fall
);
    ////////////////////////////////////////////////////////////////////////
    // Wired level: pull-up unless a party pulls low
    assign pin_level = !(ext_low || (rst_pin_oe && !rst_pin_out));

    // Falling edge marker of the selected oscillator clock
    initial osc_fall = 1'b0;
    always @(posedge clk) begin
        osc_fall <= ~osc_fall;
    end
endmodule : reset_pin_partner

// ---- bench/reset_sequencer_sim_counter_tb.sv ----
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Pin partner models the pulled-up wire and oscillator edges
// Notes:   Measured lengths allow two cycles of register delay
`timescale 1ns/100ps
module reset_sequencer_sim_counter_tb;
    typedef struct packed {
        reset_seq_pkg::src_t s;
        reset_seq_pkg::cpu_t c;
        logic [7:0]          cause;
        logic                lng;
    } row_t;
    localparam int LONG_PIN = 4128;
    logic                clk, rst, osc_fall_en, rst_pin_in, ext_low;
    logic                monitor_mode, avs_read, avs_write, avs_waitrequest;
    reset_seq_pkg::src_t src;
    reset_seq_pkg::cpu_t cpu;
    logic [3:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata, rd;
    logic                rst_pin_out, rst_pin_oe, internal_reset_signal;
    logic                clock_gen_output, internal_bus_clocks;
    logic [15:0]         reset_vector;
    int                  error_cnt, compares, n;
    row_t                rows [7];

    ////////////////////////////////////////////////////////////////////////
    // Design and pin partner
    reset_sequencer DUT (.clk(clk), .rst(rst), .osc_fall_en(osc_fall_en),
        .rst_pin_in(rst_pin_in), .rst_pin_test_high_voltage(1'b0), .ext_interrupt_pin_one_test_high_voltage(1'b0),
        .monitor_mode(monitor_mode), .break_state(1'b0), .src(src),
        .cpu(cpu), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .internal_reset_signal(internal_reset_signal),
        .clock_gen_output(clock_gen_output),
        .internal_bus_clocks(internal_bus_clocks),
        .reset_vector(reset_vector));
    reset_pin_partner pin (.clk(clk), .rst_pin_oe(rst_pin_oe),
        .rst_pin_out(rst_pin_out), .ext_low(ext_low),
        .pin_level(rst_pin_in), .osc_fall(osc_fall_en));

    // Clock and hang guard
    always #20 clk = ~clk;
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task chk_rng(input int got, input int lo);
        chk((got >= lo - 2 && got <= lo + 2) ? 32'(lo) : 32'(got), 32'(lo));
    endtask : chk_rng
    function automatic logic sig(input int w);
        return (w == 0) ? internal_reset_signal
             : (w == 1) ? rst_pin_oe : internal_bus_clocks;
    endfunction : sig
    // Counts cycles while a watched output holds a level
    task run_len(input int w, input logic lvl, output int k);
        k = 0;
        while (sig(w) === lvl && k < 6000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 6000) begin
            error_cnt++;
            complete_run();
        end
    endtask : run_len
    // Avalon access held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            complete_run();
        end
    endtask : bus
    task pulse(input reset_seq_pkg::src_t s, input reset_seq_pkg::cpu_t c);
        @(posedge clk);
        src <= s;
        cpu <= c;
        @(posedge clk);
        src <= '0;
        cpu <= '0;
    endtask : pulse
    // One reset: pin drive length, then internal reset tail
    task seq(input logic [15:0] vec, input int pl);
        run_len(1, 1'b0, n);
        chk({31'h0, internal_reset_signal}, 32'h1);
        chk({16'h0, reset_vector}, {16'h0, vec});
        run_len(1, 1'b1, n);
        chk_rng(n, pl);
        run_len(0, 1'b1, n);
        chk_rng(n, 32);
    endtask : seq
    task complete_run();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 0; rst = 1; ext_low = 0; monitor_mode = 0; src = '0; cpu = '0;
        avs_address = '0; avs_read = 0; avs_write = 0; avs_writedata = '0;
        error_cnt = 0; compares = 0;
        rows[0] = {5'h08, 22'h000000, 8'h02, 1'b1};
        rows[1] = {5'h04, 22'h000000, 8'h10, 1'b0};
        rows[2] = {5'h02, 22'h000000, 8'h08, 1'b0};
        rows[3] = {5'h01, 22'h000000, 8'h04, 1'b0};
        rows[4] = {5'h00, 22'h200000, 8'h10, 1'b0};
        rows[5] = {5'h00, 22'h0C0000, 8'h08, 1'b0};
        rows[6] = {5'h10, 22'h000000, 8'h80, 1'b1};
        repeat (16) @(posedge clk);
        chk({31'h0, clock_gen_output}, 32'h1);
        chk({31'h0, internal_bus_clocks}, 32'h0);
        rst <= 1'b0;
        seq(reset_seq_pkg::VEC_NORMAL, LONG_PIN);
        bus(1'b0, reset_seq_pkg::CAUSE_ADDR, '0);
        chk(rd, 32'h80);
        chk({31'h0, internal_bus_clocks}, 32'h1);
        bus(1'b0, 4'h2, '0);
        chk(rd, '0);
        $display("test power-on done");
        for (int i = 0; i < 7; i++) begin
            pulse(rows[i].s, rows[i].c);
            seq(reset_seq_pkg::VEC_NORMAL, rows[i].lng ? LONG_PIN : 32);
            bus(1'b0, reset_seq_pkg::CAUSE_ADDR, '0);
            chk(rd, {24'h0, rows[i].cause});
        end
        $display("test sources done");
        bus(1'b1, reset_seq_pkg::CTRL_ADDR, 32'h2);
        pulse('0, 22'h100000);
        seq(reset_seq_pkg::VEC_NORMAL, 32);
        bus(1'b0, reset_seq_pkg::CAUSE_ADDR, '0);
        chk(rd, 32'h10);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, reset_seq_pkg::CTRL_ADDR, k ? 32'h5 : 32'h7);
            pulse('0, 22'h100000);
            run_len(2, 1'b1, n);
            pulse('0, 22'h020000);
            run_len(2, 1'b0, n);
            chk_rng(n, k ? 4096 : 32);
        end
        $display("test stop done");
        bus(1'b1, reset_seq_pkg::WDOG_ADDR, 32'hA5);
        bus(1'b0, reset_seq_pkg::WDOG_ADDR, '0);
        chk(rd, '0);
        pulse('0, 22'h01FFFF);
        bus(1'b0, reset_seq_pkg::PRESC_ADDR, '0);
        chk({25'h0, rd[12:6]}, '0);
        pulse('0, 22'h040000);
        repeat (10) @(posedge clk);
        chk({31'h0, internal_reset_signal}, 32'h0);
        monitor_mode <= 1'b1;
        pulse(5'h01, '0);
        seq(reset_seq_pkg::VEC_MONITOR, 32);
        monitor_mode <= 1'b0;
        bus(1'b0, reset_seq_pkg::CAUSE_ADDR, '0);
        chk(rd, 32'h04);
        $display("test service and monitor done");
        for (int k = 0; k < 2; k++) begin
            ext_low <= 1'b1;
            repeat (k ? 20 : 70) @(posedge clk);
            ext_low <= 1'b0;
            repeat (4) @(posedge clk);
            run_len(0, 1'b1, n);
            bus(1'b0, reset_seq_pkg::CAUSE_ADDR, '0);
            chk(rd, k ? 32'h0 : 32'h40);
        end
        $display("test pin reset done");
        complete_run();
    end
endmodule : reset_sequencer_sim_counter_tb
